// file: hw/dcm_pkg.sv
package dcm_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int BE_W = 8;
  localparam int LINE_BYTES = 32;
  localparam int BEATS = 4;
  localparam int CACHE_BYTES = 8192;
  localparam int ICACHE_BYTES = 16384;
  localparam int DEF_WAYS = 2;
  localparam int QW_LSB = 3;
  localparam int APB_AW = 12;

  // Register byte offsets
  localparam logic [APB_AW-1:0] REG_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] REG_STATUS = 12'h004;
  localparam logic [APB_AW-1:0] REG_RANGE_BASE = 12'h008;
  localparam logic [APB_AW-1:0] REG_RANGE_LIMIT = 12'h00c;

  // Control register fields
  localparam int CTRL_CD_BIT = 0;
  localparam int CTRL_NW_BIT = 1;
  localparam int CTRL_WA_BIT = 2;
  localparam int CTRL_INVALIDATE_INSTRUCTION_BIT = 3;
  localparam int CTRL_WRITEBACK_INVALIDATE_INSTRUCTION_BIT = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0003;
  localparam logic [31:0] RANGE_RST = 32'h0000_0000;

  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CB_BIT = 1;
  localparam int STAT_OP_BIT = 2;

  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;

  typedef enum logic [1:0] {MESI_I, MESI_S, MESI_E, MESI_M} dcm_mesi_t;

  typedef enum logic [1:0] {
    SPEC_NONE, SPEC_FLUSH, SPEC_FLUSH_ACK, SPEC_WRITEBACK
  } dcm_spec_t;

  typedef enum logic [1:0] {OP_NONE, OP_FLUSH, OP_INVALIDATE_INSTRUCTION, OP_WRITEBACK_INVALIDATE_INSTRUCTION} dcm_op_t;

  typedef struct packed {
    logic we;
    logic page_cache_disable;
    logic page_write_through;
    logic [BE_W-1:0] be;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dcm_cpu_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic burst;
    logic cacheable_n;
    logic page_cache_disable;
    logic page_write_through;
    dcm_spec_t spec;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dcm_bus_req_t;

endpackage : dcm_pkg

// file: hw/dcm_cache_ctrl.sv
// How it works
// - 8 KB data, 32-byte lines, separate instruction cache
// - Line refill is four-beat aligned burst
// - Caches stay disabled until software enables
// - Page disable or enable pin blocks caching
// - Two-bit MESI state per data line
// - Inquire compares tags and copy-back buffer
// - Page attributes driven onto bus pins
// - Modified victim parked, written after read
// - Requested word first, valid after last
// - Flush: write back, invalidate, flush-acknowledge
// - Invalidate: drop all, flush cycle
// - Writeback-invalidate: write-back then flush cycles
// - Read hit served locally, state kept
// - Cacheable, writeback select, no PAGE_WRITE_THROUGH: Exclusive
// - Cacheable, writethrough select: Shared
// - Uncacheable fill keeps line Invalid
// - Invalid way first, else random victim
// - Clean victim discarded, install after four
// - Dirty victim buffered while new line read
// - M/E write local; S write goes through unless NW bit set
// - Allocatable write miss becomes fill then hit
// - Write allocation decided by WA bit and range registers
// - Write to E makes M, M stays
// - Writethrough result picks Exclusive or Shared
`timescale 1ns/1ps
module dcm_cache_ctrl
  import dcm_pkg::*;
#(
  parameter int WAYS = DEF_WAYS // Power of two, at least two
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_valid,
  input wire dcm_cpu_req_t cpu_req,
  output logic cpu_ready,
  output logic cpu_rvalid,
  output logic [DATA_W-1:0] cpu_rdata,
  output logic cpu_done,
  input wire logic flush_in,
  output dcm_bus_req_t bus_req,
  input wire logic bus_rdy,
  input wire logic [DATA_W-1:0] bus_rdata,
  input wire logic cache_enable_n,
  input wire logic writeback_select,
  input wire logic snoop_valid,
  input wire logic [ADDR_W-1:0] snoop_addr,
  input wire logic icache_snoop_hit,
  output logic snoop_hit,
  output logic snoop_hitm
);

  localparam int LINES = CACHE_BYTES / LINE_BYTES;
  localparam int SETS = LINES / WAYS;
  localparam int IDX_W = $clog2(SETS);
  localparam int OFF_W = $clog2(LINE_BYTES);
  localparam int QW_W = $clog2(BEATS);
  localparam int TAG_W = ADDR_W - IDX_W - OFF_W;
  localparam int WAY_W = $clog2(WAYS);
  localparam int LN_W = IDX_W + WAY_W;
  localparam logic [QW_W-1:0] LAST_BEAT = QW_W'(BEATS - 1);
  localparam logic [LN_W-1:0] LAST_LINE = LN_W'(LINES - 1);

  typedef enum {
    ST_IDLE, ST_LOOK, ST_FILL, ST_SINGLE, ST_CBWR, ST_SCAN, ST_SPEC
  } dcm_state_t;

  function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a);
    tag_of = a[ADDR_W-1 -: TAG_W];
  endfunction : tag_of

  function automatic logic [IDX_W-1:0] set_of(input logic [ADDR_W-1:0] a);
    set_of = a[OFF_W +: IDX_W];
  endfunction : set_of

  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_d,
    input logic [DATA_W-1:0] new_d,
    input logic [BE_W-1:0] be
  );
    merge = old_d;
    for (int b = 0; b < BE_W; b++)
      if (be[b])
        merge[b*8 +: 8] = new_d[b*8 +: 8];
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Storage and control state

  logic [TAG_W-1:0] tag_q [LINES];
  dcm_mesi_t st_q [LINES];
  logic [DATA_W-1:0] data_q [LINES][BEATS];
  logic [DATA_W-1:0] lb_q [BEATS];
  logic [DATA_W-1:0] cb_data_q [BEATS];
  logic [ADDR_W-1:0] cb_addr_q;
  logic cb_valid_q;
  dcm_state_t state_q;
  dcm_cpu_req_t r_q;
  dcm_op_t op_q;
  logic req_open_q, alloc_done_q, wt_q, spec2_q;
  logic ken_n_q, wbs_q;
  logic [WAY_W-1:0] way_q;
  logic [QW_W-1:0] beat_q;
  logic [LN_W-1:0] scan_q;
  logic [15:0] lfsr_q;
  logic [31:0] ctrl_q, rbase_q, rlimit_q;
  logic flush_s1_q, flush_s2_q, flush_s3_q;
  logic flush_pend_q, invalidate_instruction_pend_q, writeback_invalidate_instruction_pend_q;

  ////////////////////////////////////////////////////////////////////////////
  // Lookup

  logic hit;
  logic [WAY_W-1:0] hit_way, vic_way;
  logic [LN_W-1:0] hit_ln, vic_ln;
  logic cacheable, alloc_ok, op_take;

  always_comb
  begin
    hit = 1'b0;
    hit_way = '0;
    vic_way = lfsr_q[WAY_W-1:0];
    for (int w = WAYS - 1; w >= 0; w--)
    begin
      if (st_q[{set_of(r_q.addr), w[WAY_W-1:0]}] != MESI_I &&
          tag_q[{set_of(r_q.addr), w[WAY_W-1:0]}] == tag_of(r_q.addr))
      begin
        hit = 1'b1;
        hit_way = w[WAY_W-1:0];
      end
      if (st_q[{set_of(r_q.addr), w[WAY_W-1:0]}] == MESI_I)
      begin
        vic_way = w[WAY_W-1:0];
      end
    end
  end

  assign hit_ln = {set_of(r_q.addr), hit_way};
  assign vic_ln = {set_of(r_q.addr), vic_way};
  assign cacheable = !r_q.page_cache_disable && !ctrl_q[CTRL_CD_BIT];
  assign alloc_ok = ctrl_q[CTRL_WA_BIT] && !alloc_done_q &&
                    r_q.addr >= rbase_q && r_q.addr <= rlimit_q;
  assign op_take = state_q == ST_IDLE && !(cpu_valid && cpu_ready) &&
                   (flush_pend_q || invalidate_instruction_pend_q || writeback_invalidate_instruction_pend_q);

  logic fill_last, wr_hit;
  logic [QW_W-1:0] cur_qw;
  assign cur_qw = bus_req.addr[QW_LSB +: QW_W];
  assign fill_last = state_q == ST_FILL && bus_rdy && beat_q == LAST_BEAT;
  assign wr_hit = state_q == ST_LOOK && r_q.we && hit;

  ////////////////////////////////////////////////////////////////////////////
  // Data and tag arrays, no reset needed

  always_ff @(posedge pclk)
  begin
    if (fill_last)
    begin
      tag_q[{set_of(r_q.addr), way_q}] <= tag_of(r_q.addr);
      for (int b = 0; b < BEATS; b++)
        data_q[{set_of(r_q.addr), way_q}][b] <=
          (b[QW_W-1:0] == cur_qw) ? bus_rdata : lb_q[b];
    end
    if (wr_hit)
      data_q[hit_ln][r_q.addr[QW_LSB +: QW_W]] <=
        merge(data_q[hit_ln][r_q.addr[QW_LSB +: QW_W]], r_q.wdata, r_q.be);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Victim randomiser

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lfsr_q <= LFSR_SEED;
    else
      lfsr_q <= (lfsr_q >> 1) ^ (lfsr_q[0] ? LFSR_TAPS : 16'h0000);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flush pin synchroniser and maintenance requests

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flush_s1_q <= 1'b0;
      flush_s2_q <= 1'b0;
      flush_s3_q <= 1'b0;
      flush_pend_q <= 1'b0;
      invalidate_instruction_pend_q <= 1'b0;
      writeback_invalidate_instruction_pend_q <= 1'b0;
    end
    else
    begin
      flush_s1_q <= flush_in;
      flush_s2_q <= flush_s1_q;
      flush_s3_q <= flush_s2_q;
      // New request wins over the take in the same cycle
      if (flush_s2_q && !flush_s3_q)
        flush_pend_q <= 1'b1;
      else if (op_take)
        flush_pend_q <= 1'b0;
      if (psel && penable && pready && pwrite && paddr == REG_CTRL &&
          pwdata[CTRL_INVALIDATE_INSTRUCTION_BIT])
        invalidate_instruction_pend_q <= 1'b1;
      else if (op_take && !flush_pend_q)
        invalidate_instruction_pend_q <= 1'b0;
      if (psel && penable && pready && pwrite && paddr == REG_CTRL &&
          pwdata[CTRL_WRITEBACK_INVALIDATE_INSTRUCTION_BIT])
        writeback_invalidate_instruction_pend_q <= 1'b1;
      else if (op_take && !flush_pend_q && !invalidate_instruction_pend_q)
        writeback_invalidate_instruction_pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequencer

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      for (int l = 0; l < LINES; l++)
        st_q[l] <= MESI_I;
      for (int b = 0; b < BEATS; b++)
      begin
        lb_q[b] <= '0;
        cb_data_q[b] <= '0;
      end
      cb_addr_q <= '0;
      cb_valid_q <= 1'b0;
      r_q <= '0;
      op_q <= OP_NONE;
      req_open_q <= 1'b0;
      alloc_done_q <= 1'b0;
      wt_q <= 1'b0;
      spec2_q <= 1'b0;
      ken_n_q <= 1'b1;
      wbs_q <= 1'b0;
      way_q <= '0;
      beat_q <= '0;
      scan_q <= '0;
      bus_req <= '0;
      cpu_ready <= 1'b0;
      cpu_rvalid <= 1'b0;
      cpu_rdata <= '0;
      cpu_done <= 1'b0;
    end
    else
    begin
      cpu_rvalid <= 1'b0;
      cpu_done <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          cpu_ready <= !op_take;
          if (cpu_valid && cpu_ready)
          begin
            r_q <= cpu_req;
            req_open_q <= 1'b1;
            alloc_done_q <= 1'b0;
            cpu_ready <= 1'b0;
            state_q <= ST_LOOK;
          end
          else if (op_take)
          begin
            op_q <= flush_pend_q ? OP_FLUSH :
                    (invalidate_instruction_pend_q ? OP_INVALIDATE_INSTRUCTION : OP_WRITEBACK_INVALIDATE_INSTRUCTION);
            scan_q <= '0;
            state_q <= ST_SCAN;
          end
        end
        ST_LOOK:
        begin
          bus_req.page_cache_disable <= r_q.page_cache_disable;
          bus_req.page_write_through <= r_q.page_write_through;
          bus_req.spec <= SPEC_NONE;
          beat_q <= '0;
          wt_q <= 1'b0;
          if (hit && !r_q.we)
          begin
            cpu_rvalid <= 1'b1;
            cpu_rdata <= data_q[hit_ln][r_q.addr[QW_LSB +: QW_W]];
            cpu_done <= 1'b1;
            req_open_q <= 1'b0;
            state_q <= ST_IDLE;
          end
          else if (hit && (st_q[hit_ln] != MESI_S ||
                           ctrl_q[CTRL_NW_BIT]))
          begin
            if (st_q[hit_ln] != MESI_S)
              st_q[hit_ln] <= MESI_M;
            cpu_done <= 1'b1;
            req_open_q <= 1'b0;
            state_q <= ST_IDLE;
          end
          else if (hit || !cacheable || (r_q.we && !alloc_ok))
          begin
            // Uncached read, plain write, or writethrough of S line
            wt_q <= hit;
            way_q <= hit_way;
            bus_req.valid <= 1'b1;
            bus_req.write <= r_q.we;
            bus_req.burst <= 1'b0;
            bus_req.cacheable_n <= 1'b1;
            bus_req.addr <= r_q.addr;
            bus_req.wdata <= r_q.wdata;
            state_q <= ST_SINGLE;
          end
          else if (!(st_q[vic_ln] == MESI_M && cb_valid_q))
          begin
            way_q <= vic_way;
            if (st_q[vic_ln] == MESI_M)
            begin
              cb_valid_q <= 1'b1;
              cb_addr_q <= {tag_q[vic_ln], set_of(r_q.addr),
                            {OFF_W{1'b0}}};
              for (int b = 0; b < BEATS; b++)
                cb_data_q[b] <= data_q[vic_ln][b];
            end
            // Victim leaves the directory until the new line lands
            st_q[vic_ln] <= MESI_I;
            bus_req.valid <= 1'b1;
            bus_req.write <= 1'b0;
            bus_req.burst <= 1'b1;
            bus_req.cacheable_n <= 1'b0;
            bus_req.addr <= {r_q.addr[ADDR_W-1:QW_LSB],
                             {QW_LSB{1'b0}}};
            state_q <= ST_FILL;
          end
        end
        ST_FILL:
        begin
          if (bus_rdy)
          begin
            lb_q[cur_qw] <= bus_rdata;
            beat_q <= beat_q + 1'b1;
            // Wrap within the line so the burst stays aligned
            bus_req.addr[QW_LSB +: QW_W] <= cur_qw + 1'b1;
            if (beat_q == '0)
            begin
              ken_n_q <= cache_enable_n;
              wbs_q <= writeback_select;
              if (!r_q.we)
              begin
                cpu_rvalid <= 1'b1;
                cpu_rdata <= bus_rdata;
              end
            end
            if (beat_q == LAST_BEAT)
            begin
              bus_req.valid <= 1'b0;
              if (ken_n_q)
                st_q[{set_of(r_q.addr), way_q}] <= MESI_I;
              else if (wbs_q && !r_q.page_write_through)
                st_q[{set_of(r_q.addr), way_q}] <= MESI_E;
              else
                st_q[{set_of(r_q.addr), way_q}] <= MESI_S;
              alloc_done_q <= 1'b1;
              if (!r_q.we)
              begin
                cpu_done <= 1'b1;
                req_open_q <= 1'b0;
              end
              state_q <= cb_valid_q ? ST_CBWR :
                         (r_q.we ? ST_LOOK : ST_IDLE);
            end
          end
        end
        ST_SINGLE:
        begin
          if (bus_rdy)
          begin
            bus_req.valid <= 1'b0;
            if (!r_q.we)
            begin
              cpu_rvalid <= 1'b1;
              cpu_rdata <= bus_rdata;
            end
            if (wt_q)
              st_q[{set_of(r_q.addr), way_q}] <=
                (writeback_select && !r_q.page_write_through) ? MESI_E : MESI_S;
            cpu_done <= 1'b1;
            req_open_q <= 1'b0;
            state_q <= cb_valid_q ? ST_CBWR : ST_IDLE;
          end
        end
        ST_CBWR:
        begin
          bus_req.valid <= 1'b1;
          bus_req.write <= 1'b1;
          bus_req.burst <= 1'b1;
          bus_req.cacheable_n <= 1'b1;
          bus_req.spec <= SPEC_NONE;
          bus_req.addr <= cb_addr_q + ADDR_W'({beat_q, {QW_LSB{1'b0}}});
          bus_req.wdata <= cb_data_q[beat_q];
          if (bus_req.valid && bus_rdy)
          begin
            if (beat_q == LAST_BEAT)
            begin
              bus_req.valid <= 1'b0;
              cb_valid_q <= 1'b0;
              beat_q <= '0;
              state_q <= op_q != OP_NONE ? ST_SCAN :
                         (req_open_q ? ST_LOOK : ST_IDLE);
            end
            else
            begin
              beat_q <= beat_q + 1'b1;
              bus_req.addr <= cb_addr_q +
                              ADDR_W'({beat_q + 1'b1, {QW_LSB{1'b0}}});
              bus_req.wdata <= cb_data_q[beat_q + 1'b1];
            end
          end
        end
        ST_SCAN:
        begin
          beat_q <= '0;
          if (op_q != OP_INVALIDATE_INSTRUCTION && st_q[scan_q] == MESI_M)
          begin
            // Line revisited after its copy-back, now Invalid
            cb_valid_q <= 1'b1;
            cb_addr_q <= {tag_q[scan_q], scan_q[LN_W-1 -: IDX_W],
                          {OFF_W{1'b0}}};
            for (int b = 0; b < BEATS; b++)
              cb_data_q[b] <= data_q[scan_q][b];
            st_q[scan_q] <= MESI_I;
            state_q <= ST_CBWR;
          end
          else
          begin
            st_q[scan_q] <= MESI_I;
            scan_q <= scan_q + 1'b1;
            if (scan_q == LAST_LINE)
            begin
              bus_req.valid <= 1'b1;
              bus_req.write <= 1'b0;
              bus_req.burst <= 1'b0;
              bus_req.cacheable_n <= 1'b1;
              spec2_q <= op_q == OP_WRITEBACK_INVALIDATE_INSTRUCTION;
              bus_req.spec <= op_q == OP_FLUSH ? SPEC_FLUSH_ACK :
                              (op_q == OP_INVALIDATE_INSTRUCTION ? SPEC_FLUSH :
                               SPEC_WRITEBACK);
              state_q <= ST_SPEC;
            end
          end
        end
        ST_SPEC:
        begin
          if (bus_rdy)
          begin
            spec2_q <= 1'b0;
            if (spec2_q)
              bus_req.spec <= SPEC_FLUSH;
            else
            begin
              bus_req.valid <= 1'b0;
              bus_req.spec <= SPEC_NONE;
              op_q <= OP_NONE;
              state_q <= ST_IDLE;
            end
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Inquire lookup; instruction cache reports its own tag match

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      snoop_hit <= 1'b0;
      snoop_hitm <= 1'b0;
    end
    else
    begin
      snoop_hit <= snoop_valid && icache_snoop_hit;
      snoop_hitm <= 1'b0;
      if (snoop_valid && cb_valid_q &&
          cb_addr_q[ADDR_W-1:OFF_W] == snoop_addr[ADDR_W-1:OFF_W])
      begin
        snoop_hit <= 1'b1;
        snoop_hitm <= 1'b1;
      end
      for (int w = 0; w < WAYS; w++)
        if (snoop_valid &&
            st_q[{set_of(snoop_addr), w[WAY_W-1:0]}] != MESI_I &&
            tag_q[{set_of(snoop_addr), w[WAY_W-1:0]}] == tag_of(snoop_addr))
        begin
          snoop_hit <= 1'b1;
          if (st_q[{set_of(snoop_addr), w[WAY_W-1:0]}] == MESI_M)
            snoop_hitm <= 1'b1;
        end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= CTRL_RST;
      rbase_q <= RANGE_RST;
      rlimit_q <= RANGE_RST;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready)
      begin
        pslverr <= !(paddr == REG_CTRL || paddr == REG_STATUS ||
                     paddr == REG_RANGE_BASE || paddr == REG_RANGE_LIMIT);
        case (paddr)
          REG_CTRL: prdata <= {29'h0000_0000, ctrl_q[CTRL_WA_BIT:0]};
          REG_STATUS: prdata <= 32'h0000_0000 |
            (32'(state_q != ST_IDLE) << STAT_BUSY_BIT) |
            (32'(cb_valid_q) << STAT_CB_BIT) |
            (32'(flush_pend_q | invalidate_instruction_pend_q | writeback_invalidate_instruction_pend_q) << STAT_OP_BIT);
          REG_RANGE_BASE: prdata <= rbase_q;
          REG_RANGE_LIMIT: prdata <= rlimit_q;
          default: prdata <= '0;
        endcase
      end
      if (psel && penable && pready && pwrite)
        case (paddr)
          REG_CTRL: ctrl_q <= {29'h0000_0000, pwdata[CTRL_WA_BIT:0]};
          REG_RANGE_BASE: rbase_q <= pwdata;
          REG_RANGE_LIMIT: rlimit_q <= pwdata;
          default: ;
        endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_READ_HIT_LOCAL: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_LOOK && hit && !r_q.we) |=> cpu_rvalid && cpu_done &&
      state_q == ST_IDLE && !bus_req.valid)
    else $error("read hit went to the bus");
  AST_FILL_IS_BURST: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_FILL) |-> bus_req.burst && !bus_req.write &&
      !bus_req.cacheable_n)
    else $error("line fill not a cacheable read burst");
  AST_DISABLED_NO_FILL: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_LOOK && (ctrl_q[CTRL_CD_BIT] || r_q.page_cache_disable)) |=>
      state_q != ST_FILL)
    else $error("fill started while caching disabled");
  AST_DONE_AT_LAST: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_FILL && bus_rdy && !r_q.we) |=>
      cpu_done == $past(beat_q == LAST_BEAT))
    else $error("fill read completed at wrong beat");
  AST_KEN_KEEPS_INVALID: assert property (@(posedge pclk) disable iff (!presetn)
    (fill_last && ken_n_q) |=> st_q[$past({set_of(r_q.addr), way_q})] == MESI_I)
    else $error("uncacheable fill left a valid line");
  AST_EXCL_WRITE_MOD: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_hit && st_q[hit_ln] == MESI_E) |=> st_q[$past(hit_ln)] == MESI_M &&
      !bus_req.valid)
    else $error("write to exclusive line not made modified");
  AST_CB_WRITE_AFTER_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (fill_last && cb_valid_q) |=> state_q == ST_CBWR ##1 bus_req.write)
    else $error("copy-back not written after fill");
  AST_WRITEBACK_INVALIDATE_INSTRUCTION_TWO_CYCLES: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_SPEC && bus_rdy && bus_req.spec == SPEC_WRITEBACK) |=>
      bus_req.valid && bus_req.spec == SPEC_FLUSH)
    else $error("write-back cycle not followed by flush cycle");

endmodule : dcm_cache_ctrl

// file: verification/dcm_mem_model.sv
`timescale 1ns/1ps
module dcm_mem_model
  import dcm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire dcm_bus_req_t bus_req,
  output logic bus_rdy,
  output logic [DATA_W-1:0] bus_rdata,
  output int beats
);
  // Gap after each beat so the design has moved its address on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_rdy <= 1'b0;
      bus_rdata <= '0;
      beats <= 0;
    end
    else
    begin
      bus_rdy <= bus_req.valid && !bus_rdy && ($urandom_range(0, 1) == 1);
      if (bus_req.valid && !bus_rdy)
        bus_rdata <= {bus_req.addr[31:3], 3'h0, ~bus_req.addr[31:3], 3'h0};
      else
        bus_rdata <= ~bus_rdata;
      if (bus_rdy)
        beats <= beats + 1;
    end
  end
endmodule : dcm_mem_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
  import dcm_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r, v;
  logic pready, pslverr, se, cpu_valid = 0, cpu_ready, cpu_rvalid, cpu_done;
  dcm_cpu_req_t cpu_req = '0;
  logic [DATA_W-1:0] cpu_rdata, bus_rdata, rd;
  dcm_bus_req_t bus_req;
  logic bus_rdy, cache_enable_n = 0, writeback_select = 1;
  int err_count = 0, cmp_count = 0, beats, b0;
  logic flush_in = 0, snoop_valid = 0, icache_snoop_hit = 0;
  logic snoop_hit, snoop_hitm;
  logic [31:0] snoop_addr = '0;
  logic [1:0] sh;
  dcm_spec_t sp;
  always #25 pclk = ~pclk;
  dcm_cache_ctrl i_dut (.*);
  dcm_mem_model i_mem (.pclk, .presetn, .bus_req, .bus_rdy, .bus_rdata,
    .beats);
  function automatic logic [63:0] mem_val(input logic [31:0] a);
    return {a[31:3], 3'h0, ~a[31:3], 3'h0};
  endfunction : mem_val
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic cpu(input logic w, input logic [31:0] a, input logic [63:0] d);
    cpu_valid <= 1'b1;
    cpu_req <= '{we: w, page_cache_disable: 1'b0, page_write_through: 1'b0, be: 8'hff, addr: a, wdata: d};
    do @(negedge pclk); while (cpu_ready !== 1'b1);
    // Late copy-back beats of the previous request are not ours
    b0 = beats;
    @(posedge pclk);
    cpu_valid <= 1'b0;
    do
    begin
      @(negedge pclk);
      if (cpu_rvalid === 1'b1)
        rd = cpu_rdata;
    end
    while (cpu_done !== 1'b1);
    @(posedge pclk);
  endtask : cpu
  task automatic snp(input logic [31:0] a);
    snoop_valid <= 1'b1;
    snoop_addr <= a;
    @(posedge pclk);
    snoop_valid <= 1'b0;
    @(negedge pclk);
    sh = {snoop_hit, snoop_hitm};
    @(posedge pclk);
  endtask : snp
  task automatic spec_get(output dcm_spec_t s);
    do @(posedge pclk);
    while (bus_req.valid !== 1'b1 || bus_req.spec === SPEC_NONE);
    s = bus_req.spec;
    do @(posedge pclk); while (bus_req.spec === s);
  endtask : spec_get
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    r = $urandom(98185);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, REG_CTRL, 32'h0000_0000);
    `CHK(r, CTRL_RST)
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK(se, 1'b1)
    v = $urandom;
    apb(1'b1, REG_RANGE_LIMIT, v);
    apb(1'b0, REG_RANGE_LIMIT, 32'h0000_0000);
    `CHK(r, v)
    apb(1'b1, REG_CTRL, 32'h0000_0000);
    $display("registers done");
    // Critical word last in the line forces the wrap
    cpu(1'b0, 32'h0000_0058, '0);
    `CHK(rd, mem_val(32'h0000_0058))
    `CHK(beats - b0, 4)
    cpu(1'b0, 32'h0000_0040, '0);
    `CHK(beats - b0, 0)
    cpu(1'b1, 32'h0000_0048, 64'h1234_5678_9abc_def0);
    `CHK(beats - b0, 0)
    cpu(1'b0, 32'h0000_0048, '0);
    `CHK(rd, 64'h1234_5678_9abc_def0)
    $display("exclusive done");
    writeback_select <= 1'b0;
    cpu(1'b0, 32'h0000_0060, '0);
    `CHK(beats - b0, 4)
    cpu(1'b1, 32'h0000_0060, 64'h0f0f_0f0f_0f0f_0f0f);
    `CHK(beats - b0 != 0, 1'b1)
    $display("shared done");
    snp(32'h0000_0048);
    `CHK(sh, 2'b11)
    snp(32'h2000_0000);
    `CHK(sh, 2'b00)
    $display("snoop done");
    // Random reads in a 16 KB span with random cache_enable_n and writeback_select
    repeat (24)
    begin
      v = 32'h0010_0000 | ($urandom & 32'h0000_3ff8);
      cache_enable_n <= 1'($urandom_range(0, 1));
      writeback_select <= 1'($urandom_range(0, 1));
      cpu(1'b0, v, '0);
      `CHK(rd, mem_val(v))
    end
    cache_enable_n <= 1'b1;
    cpu(1'b0, 32'h2000_0000, '0);
    cpu(1'b0, 32'h2000_0000, '0);
    `CHK(beats - b0 != 0, 1'b1)
    `CHK(rd, mem_val(32'h2000_0000))
    $display("random done");
    flush_in <= 1'b1;
    repeat (4) @(posedge pclk);
    flush_in <= 1'b0;
    spec_get(sp);
    `CHK(sp, SPEC_FLUSH_ACK)
    cache_enable_n <= 1'b0;
    writeback_select <= 1'b1;
    cpu(1'b0, 32'h0000_0058, '0);
    `CHK(beats - b0, 4)
    cpu(1'b1, 32'h0000_0058, 64'h5a5a_5a5a_5a5a_5a5a);
    b0 = beats;
    apb(1'b1, REG_CTRL, 32'h0000_0010);
    spec_get(sp);
    `CHK(sp, SPEC_WRITEBACK)
    spec_get(sp);
    `CHK(sp, SPEC_FLUSH)
    @(posedge pclk);
    // One dirty line copied back plus two special cycles
    `CHK(beats - b0, BEATS + 2)
    cpu(1'b0, 32'h0000_0058, '0);
    `CHK(rd, mem_val(32'h0000_0058))
    cpu(1'b1, 32'h0000_0058, 64'h5a5a_5a5a_5a5a_5a5a);
    b0 = beats;
    apb(1'b1, REG_CTRL, 32'h0000_0008);
    spec_get(sp);
    `CHK(sp, SPEC_FLUSH)
    @(posedge pclk);
    `CHK(beats - b0, 1)
    $display("maintenance done");
    summarize();
  end
  initial
  begin
    #2_000_000;
    err_count++;
    summarize();
  end
endmodule : tb_top
